// File: logic/stc_consts.svh
// constants for the stepper control register bank
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_ADDR_TORQUE      6'h03
`define STC_ADDR_OUTPUTS     6'h04
`define STC_ADDR_INDEXER     6'h05
`define STC_ADDR_FAULTCTL    6'h06
`define STC_TORQUE_LSB       4
`define STC_SLEW_LSB         0
`define STC_RSVD1_LSB        2
`define STC_TRISTATE_BIT     7
`define STC_RSVD2_LSB        5
`define STC_CHOP_OFF_INTERVAL_LSB         3
`define STC_DECAY_LSB        0
`define STC_DIRREG_BIT       7
`define STC_STEPREG_BIT      6
`define STC_DIRSRC_BIT       5
`define STC_STEPSRC_BIT      4
`define STC_RES_LSB          0
`define STC_OLEN_BIT         3
`define STC_RST_TORQUE       8'h00
`define STC_RST_OUTPUTS      8'h0F
`define STC_RST_INDEXER      8'h00
`define STC_RST_FAULTCTL     8'h00
`define STC_TOFF0_NS         7000
`define STC_TOFF1_NS         16000
`define STC_TOFF2_NS         24000
`define STC_TOFF3_NS         32000
`define STC_CLK_NS           4
`endif

// File: logic/stc_pkg.sv
// types shared by the stepper control register bank
package stc_pkg;
  typedef enum logic [1:0] {STC_SLOW, STC_MIX30, STC_MIX60, STC_FAST} stc_decay_t;
  typedef enum logic [1:0] {STC_FIXED, STC_ADAPT_DYN, STC_ADAPT_RIPPLE} stc_scheme_t;
  typedef enum logic [3:0] {
    STC_FULL100, STC_FULL71, STC_HALF_NC, STC_HALF, STC_QUARTER, STC_EIGHTH, STC_SIXTEENTH,
    STC_1_32, STC_1_64, STC_1_128, STC_1_256, STC_RES_BAD
  } stc_res_t;
  typedef struct packed {
    logic [7:0] torqueCfg;
    logic [7:0] outputsCfg;
    logic [7:0] indexerCfg;
    logic [7:0] faultCtl;
    logic       stepPulse;
    logic [7:0] readData;
  } stc_state_t;
endpackage : stc_pkg

// File: logic/stc_off_timer.sv
// chopping off-interval cycle table
`timescale 1ns/1ps
`include "stc_consts.svh"
module stc_off_timer
  import stc_pkg::*;
(
  input  wire logic        clk,          // core clock
  input  wire logic        rstSyncN,     // synchronised reset
  input  wire logic [1:0]  offSel,       // chopping off-time code
  output logic      [15:0] offCycles     // off interval in clock cycles
);
  typedef struct packed {
    logic [15:0] cycles;
  } stc_tmr_t;
  stc_tmr_t st_reg, st_next;

  localparam logic [15:0] C0 = 16'(`STC_TOFF0_NS / `STC_CLK_NS);
  localparam logic [15:0] C1 = 16'(`STC_TOFF1_NS / `STC_CLK_NS);
  localparam logic [15:0] C2 = 16'(`STC_TOFF2_NS / `STC_CLK_NS);
  localparam logic [15:0] C3 = 16'(`STC_TOFF3_NS / `STC_CLK_NS);

  // table lookup, registered so the chopper sees a clean value
  always_comb begin
    st_next = st_reg;
    unique case (offSel)
      2'h0: st_next.cycles = C0;
      2'h1: st_next.cycles = C1;
      2'h2: st_next.cycles = C2;
      2'h3: st_next.cycles = C3;
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_reg <= '{cycles: 16'h0FA0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign offCycles = st_reg.cycles;
endmodule : stc_off_timer

// File: logic/stc_regs.sv
// stepper control configuration registers and their decoded controls
`timescale 1ns/1ps
`include "stc_consts.svh"
module stc_regs
  import stc_pkg::*;
#(
  parameter bit RESET_TRISTATE = 1'b0    // variant choice for the float default
) (
  input  wire logic        clk,               // core clock, 250 MHz
  input  wire logic        resetn,            // asynchronous reset, active low
  input  wire logic        regWrite,          // one-cycle write strobe from serial port
  input  wire logic        regRead,           // one-cycle read strobe from serial port
  input  wire logic [5:0]  regAddr,           // register address
  input  wire logic [7:0]  regWdata,          // write data
  output logic      [7:0]  regRdata,          // read data, registered
  input  wire logic        external_hiz_pin,  // external output disable pin
  input  wire logic        stepPin,           // external step input
  input  wire logic        dirPin,            // external direction input
  output logic      [3:0]  torque_scale,      // torque code
  output logic      [7:0]  torquePercentX16,  // full-scale share, units of 1/16
  output logic      [1:0]  slewSel,           // edge speed code
  output logic      [6:0]  slewVoltsPerUs,    // edge speed in V/us
  output logic             outputsHiZ,        // all bridge outputs float
  output logic      [15:0] chop_off_interval, // off interval in cycles
  output stc_decay_t       decayRising,       // decay used while current rises
  output stc_decay_t       decayFalling,      // decay used while current falls
  output stc_scheme_t      decayScheme,       // fixed or adaptive scheme
  output logic             stepAdvance,       // one-cycle indexer advance
  output logic             stepDirPositive,   // selected stepping direction
  output stc_res_t         step_resolution,   // decoded step resolution
  output logic             open_load_check_enable // open-load detection on
);
  logic       rstMeta, rstSyncN;
  stc_state_t st_reg, st_next;
  logic       stepPinDly;

  // two-stage release keeps reset removal clean against the clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  function automatic logic [6:0] slewOf(input logic [1:0] code);
    unique case (code)
      2'h0: slewOf = 7'h0A;
      2'h1: slewOf = 7'h23;
      2'h2: slewOf = 7'h32;
      2'h3: slewOf = 7'h69;
    endcase
  endfunction : slewOf

  function automatic stc_res_t resOf(input logic [3:0] code);
    if (code > 4'hA) resOf = STC_RES_BAD;
    else resOf = stc_res_t'(code);
  endfunction : resOf

  // register writes; step bit is not stored, it becomes a pulse
  always_comb begin
    st_next = st_reg;
    st_next.stepPulse = 1'b0;
    if (regWrite) begin
      unique case (regAddr)
        `STC_ADDR_TORQUE:   st_next.torqueCfg  = regWdata;
        `STC_ADDR_OUTPUTS:  st_next.outputsCfg = regWdata;
        `STC_ADDR_INDEXER: begin
          st_next.indexerCfg = regWdata & ~(8'h01 << `STC_STEPREG_BIT);
          st_next.stepPulse  = regWdata[`STC_STEPREG_BIT];
        end
        `STC_ADDR_FAULTCTL: st_next.faultCtl[`STC_OLEN_BIT] = regWdata[`STC_OLEN_BIT];
        default: ;
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        `STC_ADDR_TORQUE:   st_next.readData = st_reg.torqueCfg;
        `STC_ADDR_OUTPUTS:  st_next.readData = st_reg.outputsCfg;
        `STC_ADDR_INDEXER:  st_next.readData = st_reg.indexerCfg;
        `STC_ADDR_FAULTCTL: st_next.readData = st_reg.faultCtl;
        default:            st_next.readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_reg <= '{torqueCfg: `STC_RST_TORQUE,
                  outputsCfg: (RESET_TRISTATE ? 8'h80 : 8'h00) | `STC_RST_OUTPUTS,
                  indexerCfg: `STC_RST_INDEXER, faultCtl: `STC_RST_FAULTCTL,
                  stepPulse: 1'b0, readData: 8'h00};
      stepPinDly <= 1'b0;
    end else begin
      st_reg     <= st_next;
      stepPinDly <= stepPin;
    end
  end

  assign regRdata = st_reg.readData;

  // torque and edge speed
  assign torque_scale     = st_reg.torqueCfg[`STC_TORQUE_LSB +: 4];
  assign torquePercentX16 = 8'h10 - {4'h0, torque_scale};
  assign slewSel          = st_reg.torqueCfg[`STC_SLEW_LSB +: 2];
  assign slewVoltsPerUs   = slewOf(slewSel);

  // either source alone floats the bridge; pin needs no register access
  assign outputsHiZ = st_reg.outputsCfg[`STC_TRISTATE_BIT] | external_hiz_pin;

  stc_off_timer u_off (
    .clk       (clk),
    .rstSyncN  (rstSyncN),
    .offSel    (st_reg.outputsCfg[`STC_CHOP_OFF_INTERVAL_LSB +: 2]),
    .offCycles (chop_off_interval)
  );

  // decay decode
  always_comb begin
    decayRising  = STC_SLOW;
    decayFalling = STC_SLOW;
    decayScheme  = STC_FIXED;
    unique case (st_reg.outputsCfg[`STC_DECAY_LSB +: 3])
      3'h0: decayFalling = STC_SLOW;
      3'h1: decayFalling = STC_MIX30;
      3'h2: decayFalling = STC_MIX60;
      3'h3: decayFalling = STC_FAST;
      3'h4: begin
        decayRising  = STC_MIX30;
        decayFalling = STC_MIX30;
      end
      3'h5: begin
        decayRising  = STC_MIX60;
        decayFalling = STC_MIX60;
      end
      3'h6: decayScheme = STC_ADAPT_DYN;
      3'h7: decayScheme = STC_ADAPT_RIPPLE;
    endcase
  end

  // step and direction source selection; pin step is edge detected
  assign stepAdvance = st_reg.indexerCfg[`STC_STEPSRC_BIT] ? st_reg.stepPulse
                                                           : (stepPin & ~stepPinDly);
  assign stepDirPositive = st_reg.indexerCfg[`STC_DIRSRC_BIT] ?
                           st_reg.indexerCfg[`STC_DIRREG_BIT] : dirPin;
  // full, half and micro step codes decode through one lookup
  assign step_resolution = resOf(st_reg.indexerCfg[`STC_RES_LSB +: 4]);
  assign open_load_check_enable = st_reg.faultCtl[`STC_OLEN_BIT];
endmodule : stc_regs

// File: bench/stc_regs_asserts.sv
// checker for the stepper control register bank
`timescale 1ns/1ps
module stc_regs_asserts (
  input wire logic       clk,                   // core clock
  input wire logic       resetn,                // reset, active low
  input wire logic       regWrite,              // write strobe
  input wire logic [5:0] regAddr,               // address
  input wire logic [7:0] regWdata,              // write data
  input wire logic       external_hiz_pin,      // float pin
  input wire logic       stepPin,               // step pin
  input wire logic       dirPin,                // direction pin
  input wire logic [3:0] torque_scale,          // torque code
  input wire logic       outputsHiZ,            // outputs float
  input wire logic       stepAdvance,           // step pulse
  input wire logic       stepDirPositive,       // direction
  input wire logic       open_load_check_enable // open-load on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // write decodes shared by the properties
  wire w3 = regWrite && regAddr == 6'h03;
  wire w4 = regWrite && regAddr == 6'h04;
  wire w5 = regWrite && regAddr == 6'h05;
  chk_pin_float: assert property (external_hiz_pin |-> outputsHiZ)
    else $error("pin float lost");
  chk_float_write: assert property (w4 |=> outputsHiZ == ($past(regWdata[7]) | external_hiz_pin))
    else $error("float bit wrong");
  chk_torque_write: assert property (w3 |=> torque_scale == $past(regWdata[7:4]))
    else $error("torque code wrong");
  chk_reg_step: assert property (w5 && regWdata[6] && regWdata[4] |=> stepAdvance ##1 !stepAdvance)
    else $error("register step not single");
  chk_no_stray: assert property (stepAdvance |-> $rose(stepPin) || $past(w5))
    else $error("stray step");
  chk_reg_dir: assert property (w5 && regWdata[5] |=> stepDirPositive == $past(regWdata[7]))
    else $error("register direction wrong");
  chk_pin_dir: assert property (w5 && !regWdata[5] |=> stepDirPositive == dirPin)
    else $error("pin direction wrong");
  chk_ol_write: assert property (regWrite && regAddr == 6'h06 |=> open_load_check_enable == $past(regWdata[3]))
    else $error("open-load bit wrong");
endmodule : stc_regs_asserts
bind stc_regs stc_regs_asserts u_chk (.clk(clk), .resetn(resetn), .regWrite(regWrite),
  .regAddr(regAddr), .regWdata(regWdata), .external_hiz_pin(external_hiz_pin),
  .stepPin(stepPin), .dirPin(dirPin), .torque_scale(torque_scale), .outputsHiZ(outputsHiZ),
  .stepAdvance(stepAdvance), .stepDirPositive(stepDirPositive),
  .open_load_check_enable(open_load_check_enable));

// File: bench/stc_host.sv
// host model driving the register strobes
`timescale 1ns/1ps
module stc_host (
  input  wire logic       clk,      // core clock
  output logic            regWrite, // write strobe
  output logic            regRead,  // read strobe
  output logic      [5:0] regAddr,  // address
  output logic      [7:0] regWdata, // write data
  input  wire logic [7:0] regRdata  // read data
);
  // one strobe cycle, set and released on falling edges
  task automatic put(input logic [5:0] a, input logic [7:0] d, input logic w);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;  // released lines never keep the stale value
    regWdata = ~d;
  endtask : put
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == 6'h05 && d[3:0] > 4'hA) return;
    if (a == 6'h04 && d[7]) put(6'h06, 8'h00, 1'b1);
    put(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    d = regRdata;
  endtask : rd
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 6'h00;
    regWdata = 8'h00;
  end
endmodule : stc_host

// File: bench/testbench.sv
// self-checking bench for the stepper control register bank
`timescale 1ns/1ps
module testbench;
  import stc_pkg::*;
  logic        clk, resetn, hizPin, stepPin, dirPin, regWrite, regRead, hiZ, adv, dirPos, olEn;
  logic [5:0]  regAddr;
  logic [7:0]  regWdata, regRdata, rdv, pct;
  logic [6:0]  slewV;
  logic [3:0]  tq;
  logic [1:0]  sl;
  logic [15:0] chop;
  stc_decay_t  rise, fall;
  stc_scheme_t sch;
  stc_res_t    res;
  int          err_count, comparisons, cycles, steps;
  logic [7:0]  rstV [4] = '{8'h00, 8'h0F, 8'h00, 8'h00};
  logic [6:0]  slewT [4] = '{7'h0A, 7'h23, 7'h32, 7'h69};
  logic [15:0] chopT [4] = '{16'h06D6, 16'h0FA0, 16'h1770, 16'h1F40};
  logic [1:0]  riseT [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [1:0]  fallT [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  logic [1:0]  schT [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  stc_host host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  stc_regs DUT (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .external_hiz_pin(hizPin),
    .stepPin(stepPin), .dirPin(dirPin), .torque_scale(tq), .torquePercentX16(pct), .slewSel(sl),
    .slewVoltsPerUs(slewV), .outputsHiZ(hiZ), .chop_off_interval(chop), .decayRising(rise),
    .decayFalling(fall), .decayScheme(sch), .stepAdvance(adv), .stepDirPositive(dirPos),
    .step_resolution(res), .open_load_check_enable(olEn));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic pinStep;
    stepPin = 1'b1;
    @(negedge clk);
    stepPin = 1'b0;
    @(negedge clk);
  endtask : pinStep
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // step counter and hang guard; under two hundred cycles are expected
  always @(posedge clk) begin
    cycles++;
    if (adv === 1'b1) steps++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {resetn, hizPin, stepPin, dirPin} = 4'h0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      host.rd(6'h03 + 6'(i), rdv);
      cmp("reset value", 16'(rstV[i]), 16'(rdv));
    end
    cmp("chop reset", 16'h0FA0, chop);
    cmp("scheme reset", 16'(STC_ADAPT_RIPPLE), 16'(sch));
    cmp("resolution reset", 16'(STC_FULL100), 16'(res));
    $display("test resets done");
    for (int i = 0; i < 16; i++) begin
      host.wr(6'h03, {4'(i), 4'(15 - i)});
      host.rd(6'h03, rdv);
      cmp("torque readback", 16'({4'(i), 4'(15 - i)}), 16'(rdv));
      cmp("torque share", 16'(16 - i), 16'(pct));
      cmp("torque code", 16'(i), 16'(tq));
      cmp("slew code", 16'(3 - i % 4), 16'(sl));
      cmp("slew", 16'(slewT[3 - i % 4]), 16'(slewV));
    end
    $display("test torque done");
    for (int i = 0; i < 8; i++) begin
      host.wr(6'h04, 8'(i * 9));
      host.rd(6'h04, rdv);
      cmp("outputs readback", 16'(i * 9), 16'(rdv));
      cmp("chop", chopT[i % 4], chop);
      cmp("scheme", 16'(schT[i]), 16'(sch));
      if (i < 6) cmp("rising decay", 16'(riseT[i]), 16'(rise));
      if (i < 6) cmp("falling decay", 16'(fallT[i]), 16'(fall));
    end
    $display("test decay done");
    host.wr(6'h06, 8'h08);
    cmp("open-load on", 16'h0001, 16'(olEn));
    host.wr(6'h04, 8'h8F);
    cmp("open-load off first", 16'h0000, 16'(olEn));
    cmp("float by register", 16'h0001, 16'(hiZ));
    host.wr(6'h04, 8'h0F);
    cmp("outputs driven", 16'h0000, 16'(hiZ));
    hizPin = 1'b1;
    #1 cmp("float by pin", 16'h0001, 16'(hiZ));
    hizPin = 1'b0;
    $display("test float done");
    host.wr(6'h05, 8'hA0);
    cmp("register direction", 16'h0001, 16'(dirPos));
    dirPin = 1'b1;
    host.wr(6'h05, 8'h20);
    cmp("register direction low", 16'h0000, 16'(dirPos));
    host.wr(6'h05, 8'h00);
    cmp("pin direction", 16'h0001, 16'(dirPos));
    steps = 0;
    host.wr(6'h05, 8'h50);
    host.rd(6'h05, rdv);
    cmp("step bit clears", 16'h0010, 16'(rdv));
    pinStep();
    cmp("register steps", 16'h0001, 16'(steps));
    host.wr(6'h05, 8'h00);
    pinStep();
    cmp("pin steps", 16'h0002, 16'(steps));
    $display("test stepping done");
    for (int i = 0; i < 11; i++) begin
      host.wr(6'h05, 8'(i));
      cmp("resolution", 16'(i), 16'(res));
    end
    host.rd(6'h07, rdv);
    cmp("unmapped read", 16'h0000, 16'(rdv));
    $display("test resolution done");
    test_done();
  end
endmodule : testbench
